// File: hw/dcc_ctrl.sv
// Added by the designer: the address map and register access over Avalon-MM.
`timescale 1ns/1ns
// Behaviour
// - 2048 lines of 32 bytes, VA 15:5 indexes
// - Processor hit needs tag and context match
// - Low five VA bits select line bytes
// - Read miss stalls, fills, strobes, then releases
// - Byte enables from VA 1:0 and size
// - Write-through write hit also goes to memory
// - Write-through write miss goes to memory only
// - Copy-back write miss: write back dirty, fill, write
// - Processor entry: vtag, context, good, multi bits
// - Snoop seeing other holder sets multi bit
// - Privileged entries skip context compare for supervisor
// - Bus entry: 24-bit ptag, good, multi, dirty
// - Bus index is superset bits plus PA 11:5
// - Snoop hit needs ptag match and good bit
// - Reset clears all bus entry good bits
// - Snoop and processor lookups run in parallel
// - Copy-back writes stay in cache only
// - Five line states from good, multi, dirty
// - Modified lines own data and supply it
// - Processor entry: invalid, exclusive or shared valid
// - Write-through uses only valid and invalid
// - Replacement always by whole lines
// - Read miss coherent read, copy-back write miss read-invalidate
// - Copy-back read fill shared if shared response low
// - Snooped read hit in copy-back mode asserts holder signal at A+2
module dcc_ctrl
    import dcc_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic P_REQ,
    input wire logic P_WRITE,
    input wire logic [31:0] P_VADDR,
    input wire logic [1:0] P_SIZE,
    input wire logic P_SUPER,
    input wire logic [CTX_W-1:0] P_CTX,
    input wire logic [2:0] P_ACC_LVL,
    input wire logic [PTAG_W-1:0] P_PTAG,
    output logic P_STALL,
    output logic P_DSTROBE,
    output logic [3:0] P_BWE,
    output logic M_REQ,
    output logic [2:0] M_CMD,
    output logic [PA_W-1:0] M_ADDR,
    input wire logic M_ACK,
    input wire logic M_SHARED_N,
    input wire logic S_VALID,
    input wire logic [1:0] S_CMD,
    input wire logic [63:0] S_ADDR_DATA,
    output logic S_MSH_N,
    output logic S_OWNER
);

    // ------------------------------------------------------------
    // Storage and reset image
    // ------------------------------------------------------------
    localparam dcc_state_type ST_RST = '{fsm: ST_IDLE, msh_n: 1'b1, wreq: 1'b1,
        cb: CTRL_CB_RST, default: '0};

    dcc_state_type st_reg; // Registered state
    dcc_state_type st_next; // Next state
    dcc_pv_type pv_arr [LINES]; // Processor tag array
    dcc_bus_type bus_arr [LINES]; // Bus tag array

    // Lookup side signals
    logic [IDX_W-1:0] idx; // Processor line select
    dcc_pv_type pe; // Selected processor entry
    dcc_bus_type be; // Bus entry at processor index
    logic hit; // Processor tag hit
    logic [3:0] bwe_now; // Enables for presented access
    logic pv_we; // Processor side tag writes
    dcc_pv_type pv_wd;
    logic bus_we;
    dcc_bus_type bus_wd;
    logic [IDX_W-1:0] t_idx; // Index for processor side writes

    // Snoop side signals
    dcc_pv_type sp; // Processor entry at snoop index
    dcc_bus_type sb; // Bus entry at snoop index
    logic shit; // Snoop compare hit
    logic sn_we; // Snoop tag update
    dcc_pv_type sn_pv;
    dcc_bus_type sn_bus;

    // ------------------------------------------------------------
    // Byte enable decode
    // ------------------------------------------------------------
    // Lane 3 is byte offset 0; wider sizes assume aligned addresses
    function automatic logic [3:0] bwe_f(input logic [1:0] a, input logic [1:0] sz);
        case (sz)
            SZ_BYTE: bwe_f = 4'h8 >> a;
            SZ_HALF: bwe_f = 4'hc >> {a[1], 1'b0};
            default: bwe_f = 4'hf;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Next state logic
    // ------------------------------------------------------------
    // One process for processor, snoop and register paths
    always_comb begin
        st_next = st_reg;
        idx = P_VADDR[15:5];
        pe = pv_arr[idx];
        be = bus_arr[idx];
        // Context is forced to match for supervisor on priv entries
        hit = pe.good && pe.vtag == P_VADDR[31:16]
            && (pe.ctx == P_CTX || (P_SUPER && pe.priv));
        bwe_now = bwe_f(P_VADDR[1:0], P_SIZE);
        pv_we = 1'b0;
        bus_we = 1'b0;
        pv_wd = pe;
        bus_wd = be;
        t_idx = idx;
        st_next.ds = 1'b0;
        st_next.bwe = 4'h0;
        case (st_reg.fsm)
            ST_IDLE: begin
                if (st_reg.stall) begin
                    // Stall drops one cycle after the strobe
                    st_next.stall = 1'b0;
                end else if (P_REQ) begin
                    st_next.wr = P_WRITE;
                    st_next.va = P_VADDR;
                    st_next.ptag = P_PTAG;
                    st_next.size = P_SIZE;
                    if (hit && !P_WRITE) begin
                        st_next.ds = 1'b1;
                    end else if (hit && st_reg.cb) begin
                        // Copy-back hit: cache only, line becomes modified
                        st_next.bwe = bwe_now;
                        bus_we = 1'b1;
                        bus_wd.dirty = 1'b1;
                        bus_wd.multi = 1'b0;
                        pv_we = 1'b1;
                        pv_wd.multi = 1'b0;
                    end else if (P_WRITE && !st_reg.cb) begin
                        // Hit writes the RAMs too; a miss leaves them alone
                        st_next.bwe = hit ? bwe_now : 4'h0;
                        st_next.stall = 1'b1;
                        st_next.mreq = 1'b1;
                        st_next.mcmd = CMD_WR;
                        st_next.maddr = {P_PTAG, P_VADDR[11:0]};
                        st_next.fsm = ST_WTHRU;
                    end else begin
                        st_next.stall = 1'b1;
                        st_next.mreq = 1'b1;
                        if (st_reg.cb && be.good && be.dirty) begin
                            // Old owner data must reach memory first
                            st_next.mcmd = CMD_WB;
                            st_next.maddr = {be.ptag, idx[6:0], 5'h00};
                            st_next.fsm = ST_WBACK;
                        end else begin
                            st_next.mcmd = P_WRITE ? CMD_RDI : CMD_RD;
                            st_next.maddr = {P_PTAG, P_VADDR[11:5], 5'h00};
                            st_next.fsm = ST_FILL;
                        end
                    end
                end
            end
            ST_WBACK: begin
                // Write-back done, fetch the new line
                if (M_ACK) begin
                    st_next.mcmd = st_reg.wr ? CMD_RDI : CMD_RD;
                    st_next.maddr = {st_reg.ptag, st_reg.va[11:5], 5'h00};
                    st_next.fsm = ST_FILL;
                end
            end
            ST_FILL: begin
                // Line loaded: install both tags together
                if (M_ACK) begin
                    st_next.mreq = 1'b0;
                    st_next.fsm = ST_DONE;
                    t_idx = st_reg.va[15:5];
                    pv_we = 1'b1;
                    bus_we = 1'b1;
                    pv_wd.good = 1'b1;
                    pv_wd.multi = st_reg.cb && !st_reg.wr && !M_SHARED_N;
                    pv_wd.priv = P_ACC_LVL[2:1] == 2'b11;
                    pv_wd.ctx = P_CTX;
                    pv_wd.vtag = st_reg.va[31:16];
                    bus_wd.good = 1'b1;
                    bus_wd.multi = pv_wd.multi;
                    bus_wd.dirty = st_reg.cb && st_reg.wr;
                    bus_wd.ptag = st_reg.ptag;
                end
            end
            ST_DONE: begin
                // Data delivered or write enabled only after the fill
                st_next.ds = !st_reg.wr;
                st_next.bwe = st_reg.wr ? bwe_f(st_reg.va[1:0], st_reg.size) : 4'h0;
                st_next.fsm = ST_IDLE;
            end
            ST_WTHRU: begin
                // Processor held until memory takes the word
                if (M_ACK) begin
                    st_next.mreq = 1'b0;
                    st_next.stall = 1'b0;
                    st_next.fsm = ST_IDLE;
                end
            end
            default: begin
                st_next = ST_RST;
            end
        endcase

        // Snoop stage A: capture address cycle
        st_next.sv = S_VALID;
        st_next.scmd = S_CMD;
        st_next.sidx = {S_ADDR_DATA[SUP_HI:SUP_LO], S_ADDR_DATA[11:5]};
        st_next.sptag = S_ADDR_DATA[35:12];
        // Snoop stage A+1: compare on the bus tags only
        sb = bus_arr[st_reg.sidx];
        sp = pv_arr[st_reg.sidx];
        shit = st_reg.sv && sb.good && sb.ptag == st_reg.sptag;
        sn_we = 1'b0;
        sn_pv = sp;
        sn_bus = sb;
        st_next.msh_n = 1'b1;
        st_next.owner = 1'b0;
        if (shit) begin
            case (st_reg.scmd)
                SN_CRD: begin
                    // Clean goes shared clean, modified goes shared modified
                    if (st_reg.cb) begin
                        st_next.msh_n = 1'b0;
                        st_next.owner = sb.dirty;
                        sn_we = 1'b1;
                        sn_bus.multi = 1'b1;
                        sn_pv.multi = 1'b1;
                    end
                end
                SN_CRI, SN_INV: begin
                    // Owner still supplies data on read-invalidate
                    st_next.owner = st_reg.cb && sb.dirty && st_reg.scmd == SN_CRI;
                    sn_we = 1'b1;
                    sn_bus.good = 1'b0;
                    sn_pv.good = 1'b0;
                end
                default: begin
                    sn_we = 1'b0;
                end
            endcase
        end

        // Register slave: one wait cycle, then answer
        st_next.wreq = 1'b1;
        if ((AVS_READ || AVS_WRITE) && st_reg.wreq) begin
            st_next.wreq = 1'b0;
            case (AVS_ADDRESS)
                CTRL_OFS: st_next.rdata = {31'h0, st_reg.cb};
                STAT_OFS: st_next.rdata = {27'h0, st_reg.mreq, st_reg.stall, st_reg.fsm};
                default: st_next.rdata = 32'h0;
            endcase
        end
        // Mode takes effect for lookups after the write
        if (AVS_WRITE && !st_reg.wreq && AVS_ADDRESS == CTRL_OFS && AVS_BYTEENABLE[0]) begin
            st_next.cb = AVS_WRITEDATA[CTRL_CB_BIT];
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            st_reg <= ST_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Tag arrays
    // ------------------------------------------------------------
    // Processor writes come last so a fill wins over a snoop update
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int i = 0; i < LINES; i++) begin
                pv_arr[i] <= '0;
                bus_arr[i] <= '0;
            end
        end else begin
            if (sn_we) begin
                pv_arr[st_reg.sidx] <= sn_pv;
                bus_arr[st_reg.sidx] <= sn_bus;
            end
            if (pv_we) begin
                pv_arr[t_idx] <= pv_wd;
            end
            if (bus_we) begin
                bus_arr[t_idx] <= bus_wd;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign AVS_READDATA = st_reg.rdata;
    assign AVS_WAITREQUEST = st_reg.wreq;
    assign P_STALL = st_reg.stall;
    assign P_DSTROBE = st_reg.ds;
    assign P_BWE = st_reg.bwe;
    assign M_REQ = st_reg.mreq;
    assign M_CMD = st_reg.mcmd;
    assign M_ADDR = st_reg.maddr;
    assign S_MSH_N = st_reg.msh_n;
    assign S_OWNER = st_reg.owner;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking dclk @(posedge MCLK);
    endclocking
    default disable iff (!RST_N);

    logic take; // Access accepted this cycle
    assign take = st_reg.fsm == ST_IDLE && !st_reg.stall && P_REQ;

    sequence rd_miss_s;
        take && !P_WRITE && !hit;
    endsequence
    sequence fill_done_s;
        st_reg.fsm == ST_FILL && M_ACK && !st_reg.wr ##1 st_reg.fsm == ST_DONE;
    endsequence
    sequence crd_hit_s;
        shit && st_reg.scmd == SN_CRD && st_reg.cb;
    endsequence

    rd_miss_stall_a: assert property (rd_miss_s |=> P_STALL && M_REQ)
        else $error("read miss did not stall");
    fill_strobe_a: assert property (fill_done_s |=> P_DSTROBE && P_STALL ##1 !P_STALL)
        else $error("strobe or release wrong after fill");
    hit_bwe_a: assert property (take && P_WRITE && hit && st_reg.cb |=> P_BWE == $past(bwe_now))
        else $error("byte enables wrong on write hit");
    wt_hit_fwd_a: assert property (take && P_WRITE && hit && !st_reg.cb
        |=> M_REQ && M_CMD == CMD_WR && P_BWE != 4'h0)
        else $error("write-through hit not forwarded");
    wt_miss_a: assert property (take && P_WRITE && !hit && !st_reg.cb
        |=> P_BWE == 4'h0 && M_CMD == CMD_WR)
        else $error("write-through miss touched cache");
    cb_wb_first_a: assert property (take && !hit && st_reg.cb && be.good && be.dirty
        |=> M_REQ && M_CMD == CMD_WB)
        else $error("dirty line not written back first");
    cb_no_mem_a: assert property (take && P_WRITE && hit && st_reg.cb |=> !M_REQ)
        else $error("copy-back hit went to memory");
    snoop_msh_a: assert property (S_VALID ##1 crd_hit_s |=> !S_MSH_N)
        else $error("holder signal missing at A+2");
    snoop_miss_a: assert property (st_reg.sv && !shit |=> S_MSH_N && !S_OWNER)
        else $error("snoop miss answered");
    no_snoop_stall_a: assert property (st_reg.fsm == ST_IDLE && !st_reg.stall && !P_REQ
        |=> !P_STALL)
        else $error("stall without processor miss");
    avs_answer_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("register access not answered");
    fill_shared_a: assert property (st_reg.fsm == ST_FILL && M_ACK && st_reg.cb && !st_reg.wr
        |=> pv_arr[st_reg.va[15:5]].multi == !$past(M_SHARED_N)
        && bus_arr[st_reg.va[15:5]].multi == !$past(M_SHARED_N))
        else $error("shared answer not kept after fill");

endmodule

// File: hw/dcc_pkg.sv
package dcc_pkg;
    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int LINES = 2048; // Lines and tag entries per array
    localparam int IDX_W = 11; // Line select width
    localparam int VTAG_W = 16; // Virtual tag width
    localparam int CTX_W = 12; // Context number width
    localparam int PTAG_W = 24; // Physical tag width
    localparam int PA_W = 36; // Physical address width

    // ------------------------------------------------------------
    // Register map (byte offsets) and reset values
    // ------------------------------------------------------------
    localparam logic [3:0] CTRL_OFS = 4'h0; // Mode control
    localparam logic [3:0] STAT_OFS = 4'h4; // Controller status
    localparam logic CTRL_CB_RST = 1'b0; // Write-through after reset
    localparam int CTRL_CB_BIT = 0; // Copy-back mode bit

    // ------------------------------------------------------------
    // Memory request and snoop command codes
    // ------------------------------------------------------------
    localparam logic [2:0] CMD_RD = 3'h1; // Coherent read, line
    localparam logic [2:0] CMD_RDI = 3'h2; // Coherent read and invalidate
    localparam logic [2:0] CMD_WR = 3'h3; // Single word write
    localparam logic [2:0] CMD_WB = 3'h4; // Whole line write-back
    localparam logic [1:0] SN_CRD = 2'h1; // Snooped coherent read
    localparam logic [1:0] SN_CRI = 2'h2; // Snooped read and invalidate
    localparam logic [1:0] SN_INV = 2'h3; // Snooped invalidate
    localparam logic [1:0] SZ_BYTE = 2'h0; // Transfer size codes
    localparam logic [1:0] SZ_HALF = 2'h1;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SUP_HI = 49; // Superset index bits on snoop bus
    localparam int SUP_LO = 46;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_WBACK = 3'h1,
        ST_FILL = 3'h2,
        ST_WTHRU = 3'h3,
        ST_DONE = 3'h4
    } dcc_fsm_type;

    // Processor tag entry: good/multi give invalid, excl or shared
    typedef struct packed {
        logic good;
        logic multi;
        logic priv;
        logic [CTX_W-1:0] ctx;
        logic [VTAG_W-1:0] vtag;
    } dcc_pv_type;

    // Bus tag entry: good/multi/dirty give the five line states
    typedef struct packed {
        logic good;
        logic multi;
        logic dirty;
        logic [PTAG_W-1:0] ptag;
    } dcc_bus_type;

    // All control state of the controller
    typedef struct packed {
        dcc_fsm_type fsm;
        logic stall;
        logic ds;
        logic [3:0] bwe;
        logic mreq;
        logic [2:0] mcmd;
        logic [PA_W-1:0] maddr;
        logic wr;
        logic [31:0] va;
        logic [PTAG_W-1:0] ptag;
        logic [1:0] size;
        logic sv;
        logic [1:0] scmd;
        logic [IDX_W-1:0] sidx;
        logic [PTAG_W-1:0] sptag;
        logic msh_n;
        logic owner;
        logic cb;
        logic wreq;
        logic [31:0] rdata;
    } dcc_state_type;
endpackage

// File: dv/dcc_mem_model.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Memory side responder for line and word operations
// ------------------------------------------------------------
module dcc_mem_model
    import dcc_pkg::*;
#(
    parameter int LAT = 3 // Wait cycles before completion
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic m_req,
    input wire logic [2:0] m_cmd,
    input wire logic [PA_W-1:0] m_addr,
    input wire logic shared_n, // Shared answer given with a fill
    output logic m_ack,
    output logic m_shared_n,
    output int ack_cnt, // Completed operations
    output logic [2:0] last_cmd,
    output logic [2:0] prev_cmd,
    output logic [PA_W-1:0] last_addr
);
    int wait_cnt; // Cycles the current request has waited
    logic hold; // Request seen just after an ack is stale
    logic flip; // Idle pattern, never a stale shared level
    // Shared answer stands only beside the ack
    assign m_shared_n = m_ack ? shared_n : flip;
    // One ack per whole operation, a line counts as one unit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            m_ack <= 1'b0;
            hold <= 1'b0;
            flip <= 1'b0;
            wait_cnt <= 0;
            ack_cnt <= 0;
            last_cmd <= 3'h0;
            prev_cmd <= 3'h0;
            last_addr <= '0;
        end else begin
            flip <= ~flip;
            m_ack <= 1'b0;
            hold <= m_ack;
            if (m_req && !m_ack && !hold) begin
                if (wait_cnt == LAT) begin
                    m_ack <= 1'b1;
                    wait_cnt <= 0;
                    ack_cnt <= ack_cnt + 1;
                    prev_cmd <= last_cmd;
                    last_cmd <= m_cmd;
                    last_addr <= m_addr;
                end else begin
                    wait_cnt <= wait_cnt + 1;
                end
            end
        end
    end
endmodule

// File: dv/dual_tag_coherent_cache_ctrl_bench.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Bench for the dual tag cache controller
// ------------------------------------------------------------
module dual_tag_coherent_cache_ctrl_bench;
    import dcc_pkg::*;
    logic MCLK, RST_N, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, P_REQ, P_WRITE, P_SUPER;
    logic [3:0] AVS_ADDRESS, AVS_BYTEENABLE, P_BWE, got_bwe;
    logic [31:0] AVS_WRITEDATA, AVS_READDATA, P_VADDR, rd;
    logic [1:0] P_SIZE, S_CMD;
    logic [CTX_W-1:0] P_CTX;
    logic [2:0] P_ACC_LVL, M_CMD, last_cmd, prev_cmd;
    logic [PTAG_W-1:0] P_PTAG;
    logic P_STALL, P_DSTROBE, M_REQ, M_ACK, M_SHARED_N, S_VALID, S_MSH_N, S_OWNER, shr_n, got_ds, got_st;
    logic [PA_W-1:0] M_ADDR, last_addr;
    logic [63:0] S_ADDR_DATA;
    int ack_cnt, base, n_mismatch, check_count;
    // Write hit table: byte offset, size, lanes
    logic [1:0] t_off [7] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h2, 2'h0};
    logic [1:0] t_sz [7] = '{SZ_BYTE, SZ_BYTE, SZ_BYTE, SZ_BYTE, SZ_HALF, SZ_HALF, 2'h2};
    logic [3:0] t_bwe [7] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'hc, 4'h3, 4'hf};
    localparam logic [31:0] VA_A = 32'h1234_0040, VA_B = 32'h2222_0080, VA_C = 32'h3333_00c0;
    localparam logic [31:0] VA_D = 32'h4444_1100, VA_E = 32'h5555_1100;
    localparam logic [23:0] PT_A = 24'h0000a1, PT_D = 24'h0000d4, PT_E = 24'h0000e5;

    dcc_ctrl uut (.*);
    dcc_mem_model mem (.clk(MCLK), .rst_n(RST_N), .m_req(M_REQ), .m_cmd(M_CMD), .m_addr(M_ADDR),
        .shared_n(shr_n), .m_ack(M_ACK), .m_shared_n(M_SHARED_N), .ack_cnt(ack_cnt),
        .last_cmd(last_cmd), .prev_cmd(prev_cmd), .last_addr(last_addr));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic fail(input string msg);
        n_mismatch++;
        $display("CHECK FAILED at %0t: %s", $time, msg);
    endtask
    task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string msg);
        check_count++;
        if (got !== exp) fail(msg);
    endtask
    // Register access, held until waitrequest low
    task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int i;
        @(posedge MCLK);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        for (i = 0; i < 50; i++) begin
            @(posedge MCLK);
            if (AVS_WAITREQUEST === 1'b0) break;
        end
        if (i == 50) fail("register bus hang");
        q = AVS_READDATA;
        {AVS_READ, AVS_WRITE} <= 2'h0;
        AVS_WRITEDATA <= ~d;
    endtask
    // One processor access; context and level stay put for the fill end
    task automatic pacc(input logic wr, input logic [31:0] va, input logic [23:0] pt, input logic [1:0] sz = 2'h2,
        input logic sup = 1'b0, input logic [11:0] ctx = 12'h6, input logic [2:0] lvl = 3'h0);
        int i;
        @(posedge MCLK);
        P_REQ <= 1'b1;
        P_WRITE <= wr;
        P_VADDR <= va;
        P_SIZE <= sz;
        P_SUPER <= sup;
        P_CTX <= ctx;
        P_ACC_LVL <= lvl;
        P_PTAG <= pt;
        @(posedge MCLK);
        P_REQ <= 1'b0;
        {got_ds, got_st, got_bwe} = '0;
        for (i = 0; i < 300; i++) begin
            @(posedge MCLK);
            if (P_DSTROBE === 1'b1) got_ds = 1'b1;
            if (P_STALL === 1'b1) got_st = 1'b1;
            got_bwe = got_bwe | P_BWE;
            if (P_STALL === 1'b0) break;
        end
        if (i == 300) fail("processor hang");
    endtask
    // Snoop address cycle, answers looked at in cycle A+2
    task automatic snp(input logic [1:0] c, input logic [63:0] a, input logic en, input logic eo);
        @(posedge MCLK);
        S_VALID <= 1'b1;
        S_CMD <= c;
        S_ADDR_DATA <= a;
        @(posedge MCLK);
        {S_VALID, S_CMD} <= 3'h0;
        S_ADDR_DATA <= ~a;
        repeat (2) @(posedge MCLK);
        chk(S_MSH_N, en, "holder signal");
        chk(S_OWNER, eo, "owner signal");
    endtask
    function automatic logic [63:0] sa(input logic [31:0] va, input logic [23:0] pt);
        return {14'h0, va[15:12], 10'h0, pt, va[11:0]};
    endfunction
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock, watchdog and tests
    // ------------------------------------------------------------
    initial begin
        MCLK = 1'b0;
        forever #2 MCLK = ~MCLK;
    end
    // Far beyond the few hundred cycles needed
    initial begin
        repeat (50000) @(posedge MCLK);
        fail("watchdog");
        wrap_up();
    end
    initial begin
        {RST_N, AVS_READ, AVS_WRITE, P_REQ, P_WRITE, P_SUPER, S_VALID, shr_n} = 8'h01;
        {AVS_ADDRESS, AVS_WRITEDATA, P_VADDR, P_SIZE, P_CTX, P_ACC_LVL, P_PTAG, S_CMD, S_ADDR_DATA} = '0;
        AVS_BYTEENABLE = 4'hf;
        repeat (8) @(posedge MCLK);
        RST_N <= 1'b1;
        chk({AVS_WAITREQUEST, S_MSH_N, P_STALL, M_REQ}, 4'hc, "reset outputs");
        av(1'b0, CTRL_OFS, 32'h0, rd);
        chk(rd, 32'h0, "mode after reset");
        av(1'b1, 4'h8, 32'h1, rd);
        av(1'b0, 4'h8, 32'h0, rd);
        chk(rd, 32'h0, "unmapped read");
        $display("test registers done");
        base = ack_cnt;
        pacc(1'b0, VA_A, PT_A, 2'h2, 1'b0, 12'h5);
        chk({got_st, got_ds}, 2'h3, "read miss stall and strobe");
        chk(last_cmd, CMD_RD, "read miss command");
        chk(last_addr, {PT_A, VA_A[11:5], 5'h0}, "line address");
        chk(ack_cnt - base, 1, "one line fill");
        pacc(1'b0, VA_A | 32'h1c, PT_A, 2'h2, 1'b0, 12'h5);
        chk({got_st, got_ds}, 2'h1, "read hit");
        pacc(1'b0, VA_A, PT_A);
        chk(got_st, 1'b1, "context mismatch misses");
        pacc(1'b0, VA_B, PT_A, 2'h2, 1'b1, 12'h1, 3'h6);
        pacc(1'b0, VA_B, PT_A, 2'h2, 1'b1, 12'h2);
        chk(got_st, 1'b0, "supervisor forced context");
        pacc(1'b0, VA_B, PT_A, 2'h2, 1'b0, 12'h2);
        chk(got_st, 1'b1, "user sees context");
        $display("test lookup done");
        for (int k = 0; k < 7; k++) begin
            base = ack_cnt;
            pacc(1'b1, VA_A | t_off[k], PT_A, t_sz[k]);
            chk(got_bwe, t_bwe[k], "byte enables");
            chk({last_cmd, 4'(ack_cnt - base)}, {CMD_WR, 4'h1}, "write through hit");
        end
        base = ack_cnt;
        pacc(1'b1, VA_C, PT_A);
        chk({got_bwe, last_cmd, 4'(ack_cnt - base)}, {4'h0, CMD_WR, 4'h1}, "write miss");
        pacc(1'b0, VA_C, PT_A);
        chk(got_st, 1'b1, "no allocate on write miss");
        snp(SN_CRD, sa(VA_C, PT_A), 1'b1, 1'b0);
        $display("test write through done");
        av(1'b1, CTRL_OFS, 32'h1, rd);
        av(1'b0, CTRL_OFS, 32'h0, rd);
        chk(rd[0], 1'b1, "copy back mode");
        snp(SN_CRD, sa(VA_D, 24'h0), 1'b1, 1'b0);
        base = ack_cnt;
        pacc(1'b1, VA_D, PT_D);
        chk({got_bwe, last_cmd, 4'(ack_cnt - base)}, {4'hf, CMD_RDI, 4'h1}, "allocate on write miss");
        base = ack_cnt;
        pacc(1'b1, VA_D | 32'h4, PT_D);
        chk({got_st, 4'(ack_cnt - base)}, 5'h0, "copy back hit stays local");
        snp(SN_CRD, sa(VA_D, PT_D), 1'b0, 1'b1);
        base = ack_cnt;
        pacc(1'b0, VA_E, PT_E);
        chk({prev_cmd, last_cmd, 4'(ack_cnt - base)}, {CMD_WB, CMD_RD, 4'h2}, "victim first");
        snp(SN_CRD, sa(VA_D, PT_D), 1'b1, 1'b0);
        snp(SN_CRD, sa(VA_E, PT_E), 1'b0, 1'b0);
        fork
            pacc(1'b0, VA_E, PT_E);
            snp(SN_CRD, sa(VA_E, PT_E), 1'b0, 1'b0);
        join
        chk(got_st, 1'b0, "snoop beside hit");
        snp(SN_INV, sa(VA_E, PT_E), 1'b1, 1'b0);
        shr_n <= 1'b0;
        pacc(1'b0, VA_E, PT_E);
        chk(got_st, 1'b1, "invalidate reaches processor tag");
        snp(SN_CRI, sa(VA_E, PT_E), 1'b1, 1'b0);
        $display("test copy back done");
        wrap_up();
    end
endmodule
